/* File: logic/ecf_pkg.sv */
// constants and types for the event recorder with chatter filter
package ecf_pkg;
  localparam int NUM_LISTS = 4;
  localparam int LIST_BITS = 24;
  localparam int NUM_BITS = 96;
  localparam int ID_W = 7;
  localparam int POS_W = 5;
  localparam int LST_W = 2;
  localparam int CNT_W = 5;
  localparam int SKIP_W = 4;
  localparam int WIN_W = 10;
  localparam int TS_W = 32;
  localparam int CS_W = 8;
  localparam int IRQ_W = 3;

  localparam logic [CNT_W-1:0] LIMIT_MIN = 5'h02;
  localparam logic [CNT_W-1:0] LIMIT_MAX = 5'h14;
  localparam logic [CNT_W-1:0] LIMIT_RST = 5'h05;
  // window in tenths of a second
  localparam logic [WIN_W-1:0] WIN_MIN = 10'h001;
  localparam logic [WIN_W-1:0] WIN_MAX = 10'h384;
  localparam logic [WIN_W-1:0] WIN_RST = 10'h00a;
  localparam logic [SKIP_W-1:0] SKIP_WINDOWS = 4'h9;
  localparam logic [ID_W-1:0] LAST_ID = 7'h5f;
  localparam logic [POS_W-1:0] LAST_POS = 5'h17;

  localparam int CLK_PERIOD_NS = 50;
  localparam int TENTH_NS = 100000000;
  localparam int TENTH_CYCLES = (TENTH_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_LIMIT = 8'h04;
  localparam logic [7:0] ADR_WIN = 8'h08;
  localparam logic [7:0] ADR_TRIG1 = 8'h0c;
  localparam logic [7:0] ADR_TRIG4 = 8'h18;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h1c;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADR_STATUS = 8'h24;
  localparam logic [7:0] ADR_DEL1 = 8'h28;
  localparam logic [7:0] ADR_DEL4 = 8'h34;
  localparam logic [7:0] ADR_STAMP = 8'h38;

  localparam int IRQ_REC = 0;
  localparam int IRQ_DEL = 1;
  localparam int IRQ_INS = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_WEND = 2'b10
  } ecf_state_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic state;
    logic [TS_W-1:0] stamp;
    logic [CS_W-1:0] csum;
  } ecf_rec_t;
endpackage

/* File: logic/ecf_recorder.sv */
// event recorder that drops chattering status bits
// Operation
// R01: compare listed bits with previous value each interval
// R02: append record with id, state, stamp, checksum
// R03: four lists of 24 bits, 96 total
// R04: suppression only while removal enable set
// R05: count limit 2..20, window 0.1..90.0 s
// R06: exceeding limit in window stops recording bit
// R07: removed bit ignored for nine windows
// R08: recheck at ninth, resume at tenth window
// R09: settings change discards pending deletion notices
// R10: removed-bit list readable as deletion report
// R11: per-bit counter cleared each window, compared
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module ecf_recorder
  import ecf_pkg::*;
#(
  parameter int TENTH_CYC = TENTH_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic interval_tick_i,
  input wire logic [NUM_BITS-1:0] status_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic rec_valid_o,
  output ecf_rec_t rec_o,
  output logic irq_o
);

  function automatic logic [31:0] wmerge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [WIN_W-1:0] clamp(
    input logic [WIN_W-1:0] v,
    input logic [WIN_W-1:0] lo,
    input logic [WIN_W-1:0] hi
  );
    logic [WIN_W-1:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  function automatic logic [CS_W-1:0] csum8(
    input logic [ID_W-1:0] id,
    input logic st,
    input logic [TS_W-1:0] ts
  );
    logic [CS_W-1:0] s;
    s = {1'b0, id} + {7'h00, st};
    for (int b = 0; b < 4; b++) begin
      s = s + ts[b*8 +: 8];
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // settings and bus

  logic del_en;
  logic [CNT_W-1:0] limit;
  logic [WIN_W-1:0] win_time;
  logic [LIST_BITS-1:0] trig [NUM_LISTS];
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [31:0] rd_val;
  logic [31:0] wv;
  logic req;
  logic wr;
  logic cfg_wr;
  logic [LST_W-1:0] tsel;

  ecf_state_t state;
  logic [ID_W-1:0] idx;
  logic [LST_W-1:0] lst;
  logic [POS_W-1:0] pos;
  logic [NUM_BITS-1:0] snap;
  logic [NUM_BITS-1:0] prev;
  logic [NUM_BITS-1:0] removed;
  logic [CNT_W-1:0] cnt [NUM_BITS];
  logic [SKIP_W-1:0] skip [NUM_BITS];
  logic [TS_W-1:0] ts;
  logic [TS_W-1:0] scan_ts;
  logic tick_pend;
  logic win_pend;
  logic [31:0] pre;
  logic [WIN_W-1:0] win_cnt;
  logic win_end;

  assign req = wb_cyc_i & wb_stb_i;
  // write lands on the edge where the master sees ack
  assign wr = req & wb_ack_o & wb_we_i;
  assign wv = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign tsel = LST_W'((wb_adr_i - ADR_TRIG1) >> 2);
  assign cfg_wr = wr & (wb_adr_i <= ADR_TRIG4);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (wb_adr_i == ADR_CTRL) begin
      rd_val[0] = del_en;
    end else if (wb_adr_i == ADR_LIMIT) begin
      rd_val[CNT_W-1:0] = limit;
    end else if (wb_adr_i == ADR_WIN) begin
      rd_val[WIN_W-1:0] = win_time;
    end else if (wb_adr_i >= ADR_TRIG1 && wb_adr_i <= ADR_TRIG4) begin
      rd_val[LIST_BITS-1:0] = trig[tsel];
    end else if (wb_adr_i == ADR_IRQ_STAT) begin
      rd_val[IRQ_W-1:0] = irq_stat;
    end else if (wb_adr_i == ADR_IRQ_MASK) begin
      rd_val[IRQ_W-1:0] = irq_mask;
    end else if (wb_adr_i == ADR_STATUS) begin
      rd_val[1:0] = state;
      rd_val[2] = tick_pend;
      rd_val[3] = win_pend;
    end else if (wb_adr_i >= ADR_DEL1 && wb_adr_i <= ADR_DEL4) begin
      rd_val[LIST_BITS-1:0] =
        removed[(wb_adr_i - ADR_DEL1) * 6 +: LIST_BITS]; // R10
    end else if (wb_adr_i == ADR_STAMP) begin
      rd_val = ts;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i && req && !wb_ack_o) begin
      wb_dat_o <= rd_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      del_en <= 1'b0;
      limit <= LIMIT_RST;
      win_time <= WIN_RST;
      irq_mask <= '0;
      for (int l = 0; l < NUM_LISTS; l++) begin
        trig[l] <= '0;
      end
    end else if (ce_i && wr) begin
      if (wb_adr_i == ADR_CTRL) begin
        del_en <= wv[0]; // R04
      end else if (wb_adr_i == ADR_LIMIT) begin
        limit <= CNT_W'(clamp(WIN_W'(wv[CNT_W-1:0]), // R05
                              WIN_W'(LIMIT_MIN), WIN_W'(LIMIT_MAX)));
      end else if (wb_adr_i == ADR_WIN) begin
        win_time <= clamp(wv[WIN_W-1:0], WIN_MIN, WIN_MAX); // R05
      end else if (wb_adr_i >= ADR_TRIG1 && wb_adr_i <= ADR_TRIG4) begin
        trig[tsel] <= LIST_BITS'(wmerge(32'(trig[tsel]), wb_dat_i,
                                        wb_sel_i)); // R03
      end else if (wb_adr_i == ADR_IRQ_MASK) begin
        irq_mask <= IRQ_W'(wmerge(32'(irq_mask), wb_dat_i, wb_sel_i));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // window timer, in tenths of a second

  assign win_end = (pre == TENTH_CYC - 1) && (win_cnt == win_time - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre <= 32'h0000_0000;
      win_cnt <= '0;
    end else if (ce_i) begin
      // a settings change starts a fresh window
      if (cfg_wr) begin
        pre <= 32'h0000_0000;
        win_cnt <= '0;
      end else if (pre == TENTH_CYC - 1) begin
        pre <= 32'h0000_0000;
        win_cnt <= win_end ? '0 : win_cnt + 1'b1;
      end else begin
        pre <= pre + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interval scan sequencer

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_pend <= 1'b0;
      win_pend <= 1'b0;
      ts <= '0;
    end else if (ce_i) begin
      // set wins over the consuming clear
      tick_pend <= interval_tick_i |
                   (tick_pend & ~(state == ST_IDLE && !win_pend));
      win_pend <= win_end | (win_pend & ~(state == ST_IDLE));
      if (interval_tick_i) begin
        ts <= ts + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      idx <= '0;
      lst <= '0;
      pos <= '0;
      snap <= '0;
      scan_ts <= '0;
    end else if (ce_i) begin
      case (state)
        ST_IDLE: begin
          // window close is settled before the next scan reads counts
          if (win_pend) begin
            state <= ST_WEND;
          end else if (tick_pend) begin
            state <= ST_SCAN; // R01
            snap <= status_i;
            scan_ts <= ts;
            idx <= '0;
            lst <= '0;
            pos <= '0;
          end
        end
        ST_SCAN: begin
          if (idx == LAST_ID) begin
            state <= ST_IDLE;
          end
          idx <= idx + 1'b1;
          if (pos == LAST_POS) begin
            pos <= '0;
            lst <= lst + 1'b1; // R03
          end else begin
            pos <= pos + 1'b1;
          end
        end
        ST_WEND: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per-bit change, chatter and removal tracking

  logic chg;
  logic cur;
  logic [CNT_W-1:0] next_cnt;
  logic over;
  logic drop;
  logic record;
  logic newly_removed;
  logic reins_any;

  assign cur = snap[idx];
  assign chg = (state == ST_SCAN) && trig[lst][pos] &&
               (cur != prev[idx]); // R01
  assign next_cnt = (cnt[idx] > limit) ? cnt[idx] : cnt[idx] + 1'b1;
  assign over = del_en && (next_cnt > limit); // R06
  assign drop = del_en && (removed[idx] || over); // R04
  assign record = chg && !drop; // R02
  assign newly_removed = chg && !removed[idx] && over; // R06

  always_comb begin
    reins_any = 1'b0;
    for (int k = 0; k < NUM_BITS; k++) begin
      if (removed[k] && skip[k] == SKIP_WINDOWS - 1'b1 &&
          cnt[k] <= limit) begin
        reins_any = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= '0;
    end else if (ce_i && state == ST_SCAN) begin
      // track unlisted bits too, so enabling one never fakes a change
      prev[idx] <= cur; // R01
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      removed <= '0;
      for (int k = 0; k < NUM_BITS; k++) begin
        cnt[k] <= '0;
        skip[k] <= '0;
      end
    end else if (ce_i) begin
      if (cfg_wr) begin
        removed <= '0;
        for (int k = 0; k < NUM_BITS; k++) begin
          cnt[k] <= '0;
          skip[k] <= '0;
        end
      end else if (state == ST_WEND) begin
        for (int k = 0; k < NUM_BITS; k++) begin
          cnt[k] <= '0; // R11
          if (removed[k]) begin
            if (skip[k] == SKIP_WINDOWS - 1'b1) begin
              skip[k] <= '0;
              if (cnt[k] <= limit) begin
                removed[k] <= 1'b0; // R08
              end
            end else begin
              skip[k] <= skip[k] + 1'b1; // R07
            end
          end
        end
      end else if (chg) begin
        cnt[idx] <= next_cnt; // R11
        if (newly_removed) begin
          removed[idx] <= 1'b1; // R06
          skip[idx] <= '0; // R07
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // record output, one cycle per record, sink must keep up

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rec_valid_o <= 1'b0;
      rec_o <= '0;
    end else if (ce_i) begin
      rec_valid_o <= record; // R02
      if (record) begin
        rec_o.id <= idx;
        rec_o.state <= cur;
        rec_o.stamp <= scan_ts;
        rec_o.csum <= csum8(idx, cur, scan_ts); // R02
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupts

  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_REC] = record;
    // a settings write undoes the removal, so no notice survives it
    irq_set[IRQ_DEL] = newly_removed && !cfg_wr; // R09
    irq_set[IRQ_INS] = (state == ST_WEND) && reins_any && !cfg_wr;
    irq_clr = '0;
    if (wr && wb_adr_i == ADR_IRQ_STAT && wb_sel_i[0]) begin
      irq_clr = wb_dat_i[IRQ_W-1:0];
    end
    if (cfg_wr) begin
      irq_clr[IRQ_DEL] = 1'b1; // R09
      irq_clr[IRQ_INS] = 1'b1; // R09
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else if (ce_i) begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

endmodule

/* File: verif/ecf_recorder_props.sv */
// assertions on the event recorder ports
`timescale 1ns/1ps
module ecf_recorder_chk
  import ecf_pkg::*;
#(
  parameter int TENTH_CYC = TENTH_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic interval_tick_i,
  input wire logic [NUM_BITS-1:0] status_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rec_valid_o,
  input wire ecf_rec_t rec_o,
  input wire logic irq_o
);
  function automatic logic [7:0] cs(input ecf_rec_t r);
    return {1'b0, r.id} + 8'(r.state) + r.stamp[31:24] + r.stamp[23:16]
      + r.stamp[15:8] + r.stamp[7:0];
  endfunction
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////
  a_ack_latency: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (
    wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
  a_unmapped_zero: assert property (
    wb_ack_o && $past(!wb_we_i && wb_adr_i >= 8'h3c) |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
  a_csum_match: assert property (
    rec_valid_o |-> rec_o.csum == cs(rec_o)) else $error("bad checksum");
  a_rec_hold: assert property (
    !rec_valid_o |-> $stable(rec_o)) else $error("record moved");
  a_id_order: assert property (
    rec_valid_o && $past(rec_valid_o) |-> rec_o.id > $past(rec_o.id))
    else $error("ids out of order");
  a_stamp_same: assert property (
    rec_valid_o && $past(rec_valid_o) |-> $stable(rec_o.stamp))
    else $error("stamp changed in scan");
  a_id_range: assert property (
    rec_valid_o |-> rec_o.id <= LAST_ID) else $error("id out of range");
  c_record: cover property (rec_valid_o);
  c_irq: cover property (irq_o);
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind ecf_recorder ecf_recorder_chk #(.TENTH_CYC(TENTH_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .interval_tick_i(interval_tick_i), .status_i(status_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rec_valid_o(rec_valid_o),
  .rec_o(rec_o), .irq_o(irq_o));

/* File: verif/tb.sv */
// self-checking bench for the event recorder
`timescale 1ns/1ps
module tb;
  import ecf_pkg::*;
  logic clk_i = 0, rst_i = 1, ce_i = 1, tick = 0;
  logic [NUM_BITS-1:0] st = '0, cur = '0;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0, rdat, dat_o;
  logic [3:0] sel = '0;
  logic we = 0, cyc = 0, stb = 0, ack, rv, irq;
  ecf_rec_t rec;
  ecf_rec_t q[$];
  int err_total = 0, n_compared = 0, ncyc = 0;
  // short tenth keeps the nine-window skip inside the run
  ecf_recorder #(.TENTH_CYC(20)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .interval_tick_i(tick), .status_i(st), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .rec_valid_o(rv),
    .rec_o(rec), .irq_o(irq));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ncyc <= ncyc + 1;
    if (rv === 1'b1)
      q.push_back(rec);
    if (ncyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  ////////////////////
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // one tick, then room for a full 96-bit scan
  task automatic tk(input logic [NUM_BITS-1:0] s);
    @(posedge clk_i);
    st <= s;
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    repeat (100) @(posedge clk_i);
  endtask
  task automatic tg(input int n);
    repeat (n) begin
      cur[1] = ~cur[1];
      tk(cur);
    end
  endtask
  ////////////////////
  task automatic t_regs;
    logic [7:0] a[4] = '{ADR_LIMIT, ADR_LIMIT, ADR_WIN, ADR_WIN};
    logic [31:0] v[4] = '{32'h1, 32'h15, 32'h0, 32'h3ff};
    logic [31:0] e[4] = '{LIMIT_MIN, LIMIT_MAX, WIN_MIN, WIN_MAX};
    bus(ADR_LIMIT, 0, 0);
    chk(rdat, LIMIT_RST);
    bus(ADR_WIN, 0, 0);
    chk(rdat, WIN_RST);
    foreach (a[i]) begin
      bus(a[i], 1, v[i]);
      bus(a[i], 0, 0);
      chk(rdat, e[i]);
    end
    bus(8'h3c, 1, 32'hffff);
    bus(8'h3c, 0, 0);
    chk(rdat, 32'h0);
  endtask
  task automatic t_record;
    logic [6:0] ids[3] = '{7'h00, 7'h2f, LAST_ID};
    // list 3 left empty so its changes must stay silent
    for (int i = 0; i < 4; i++)
      bus(ADR_TRIG1 + 8'(4 * i), 1, i == 2 ? 32'h0 : 32'hffffff);
    bus(ADR_IRQ_MASK, 1, 32'h1);
    q.delete();
    cur[0] = 1;
    cur[47] = 1;
    cur[50] = 1;
    cur[95] = 1;
    tk(cur);
    chk(q.size(), 3);
    foreach (ids[i])
      chk({q[i].id, q[i].state}, {ids[i], 1'b1});
    chk(q[0].stamp, 32'h1);
    chk(q[0].csum, 8'h02);
    chk(q[2].csum, 8'h61);
    chk(irq, 1);
    bus(ADR_IRQ_STAT, 1, 32'h1);
    @(negedge clk_i);
    chk(irq, 0);
    bus(ADR_IRQ_MASK, 1, 32'h0);
    cur[0] = 0;
    tk(cur);
    chk(irq, 0);
    bus(ADR_IRQ_STAT, 0, 0);
    chk(rdat & 32'h1, 32'h1);
    bus(ADR_STAMP, 0, 0);
    chk(rdat, 32'h2);
  endtask
  task automatic t_chatter;
    bus(ADR_WIN, 1, 32'h28);
    bus(ADR_LIMIT, 1, 32'h2);
    bus(ADR_CTRL, 1, 32'h1);
    q.delete();
    tg(3);
    chk(q.size(), 2);
    bus(ADR_DEL1, 0, 0);
    chk(rdat, 32'h2);
    repeat (3000) @(posedge clk_i);
    tg(1);
    chk(q.size(), 2);
    repeat (5000) @(posedge clk_i);
    bus(ADR_DEL1, 0, 0);
    chk(rdat, 32'h0);
    bus(ADR_IRQ_STAT, 0, 0);
    chk(rdat & 32'h6, 32'h6);
    tg(1);
    chk(q.size(), 3);
    bus(ADR_CTRL, 1, 32'h1);
    tg(3);
    chk(q.size(), 5);
    bus(ADR_LIMIT, 1, 32'h2);
    bus(ADR_DEL1, 0, 0);
    chk(rdat, 32'h0);
    bus(ADR_IRQ_STAT, 0, 0);
    chk(rdat & 32'h6, 32'h0);
    bus(ADR_CTRL, 1, 32'h0);
    q.delete();
    tg(4);
    chk(q.size(), 4);
  endtask
  ////////////////////
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_record();
    t_chatter();
    tally_and_finish();
  end
endmodule
